// ---- hw/vipr_pkg.sv ----
// Package for the vectored interrupt priority resolver.
// Assumes one 50 MHz clock and a plain byte-wide register port.
package vipr_pkg;

  // ----------------------------------------
  // Vector space
  // ----------------------------------------
  localparam int          VIPR_NUM_VEC   = 82;
  localparam int          VIPR_NUM_BYTES = 11;
  localparam int          VIPR_VEC_W     = 7;
  // One bit per vector; zero marks a number with no source behind it
  localparam logic [81:0] VIPR_ASSIGNED  =
    82'h3_0FC0_3BFF_FFEF_FFFF_FFFF;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] VIPR_FLAG_BASE = 8'h00;
  localparam logic [7:0] VIPR_EN_BASE   = 8'h10;
  localparam logic [7:0] VIPR_LVL_BASE  = 8'h20;
  localparam logic [7:0] VIPR_CTRL_ADR  = 8'h30;
  localparam logic [7:0] VIPR_STATE_ADR = 8'h31;
  localparam logic [7:0] VIPR_CORE_WORKING_REGISTER_ADR  = 8'h32;
  localparam logic [7:0] VIPR_EVT_ADR   = 8'h33;
  localparam logic [7:0] VIPR_EMSK_ADR  = 8'h34;

  // Field positions and reset values
  localparam int         VIPR_CTRL_GIEL = 0;
  localparam int         VIPR_CTRL_GIEH = 1;
  localparam int         VIPR_EVT_TAKE  = 0;
  localparam int         VIPR_EVT_RET   = 1;
  localparam int         VIPR_EVT_ABORT = 2;
  localparam logic [7:0] VIPR_CTRL_RST  = 8'h00;
  localparam logic [2:0] VIPR_EMSK_RST  = 3'h0;

  // Execution state
  typedef enum logic [1:0] {
    VIPR_ST_MAIN = 2'b00,
    VIPR_ST_LOW  = 2'b01,
    VIPR_ST_HIGH = 2'b10
  } vipr_state_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vipr_bus_t;

  // Vector offered to the core
  typedef struct packed {
    logic                  valid;
    logic                  high;
    logic [VIPR_VEC_W-1:0] vec;
  } vipr_req_t;

endpackage

// ---- hw/vipr_resolver.sv ----
// Vectored interrupt priority resolver: request flags, enables, level
// selects, nesting state and the vector handed to the core.
// Assumes sources, core and register master all run on clk.
//
// Summary of operation
// - Same-level ties settled by fixed vector order
// - Vector 0 most urgent, 81 least
// - Fixed vector per source; unassigned never win
// - Two high requests: smaller vector wins
// - Selected level overrides the fixed order
// - Set flag bit means pending, enters resolution
// - Winner vector goes to core and working register
// - Software clears most flags, some auto-clear
// - Summary flags are read-only mirrors of sources
// - Main accepts both levels; low accepts high only
// - Execution state readable in state register
// - Servicing never alters global enable bits
// - Global enable write returns to main, drops nesting
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module vipr_resolver
  import vipr_pkg::*;
#(
  parameter logic [81:0] AUTO_CLR_MASK = 82'h0,
  parameter logic [81:0] SUMMARY_MASK  = 82'h0
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire vipr_bus_t   bus,
  output logic [7:0]       rdata,
  // Peripheral sources
  input  wire logic [81:0] src_set,
  input  wire logic [81:0] src_summary,
  // Core handshake
  output vipr_req_t        core_req,
  input  wire logic        core_ack,
  input  wire logic        core_ret,
  // Interrupt to software
  output logic             irq
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if ((AUTO_CLR_MASK & SUMMARY_MASK) != 82'h0)
    $error("a flag cannot be both auto-cleared and a summary");

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Lowest set bit wins; vector 0 is the most urgent
  function automatic logic [VIPR_VEC_W-1:0] lowest(input logic [81:0] v);
    logic [VIPR_VEC_W-1:0] idx;
    idx = '0;
    for (int i = VIPR_NUM_VEC - 1; i >= 0; i--)
    begin
      if (v[i])
        idx = VIPR_VEC_W'(i);
    end
    return idx;
  endfunction

  // Byte lane of an 82-bit vector
  function automatic logic [7:0] lane(input logic [81:0] v, input int b);
    logic [87:0] w;
    w = {6'h00, v};
    return w[b*8 +: 8];
  endfunction

  // Bit i is hit by a write to the byte at base + i/8
  function automatic logic [81:0] wr_hit(input vipr_bus_t q, input logic [7:0] base);
    logic [81:0] h;
    h = '0;
    for (int i = 0; i < VIPR_NUM_VEC; i++)
    begin
      h[i] = q.wr && (q.addr == base + 8'(i / 8));
    end
    return h;
  endfunction

  // Write data spread over all lanes
  function automatic logic [81:0] spread(input logic [7:0] d);
    logic [81:0] s;
    s = '0;
    for (int i = 0; i < VIPR_NUM_VEC; i++)
    begin
      s[i] = d[i % 8];
    end
    return s;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [81:0]           flag_q;
  logic [81:0]           en_q;
  logic [81:0]           lvl_q;
  logic                  giel_q;
  logic                  gieh_q;
  vipr_state_t           state_q;
  logic                  nested_q;
  logic [VIPR_VEC_W-1:0] core_working_register_q;
  logic [2:0]            evt_q;
  logic [2:0]            emsk_q;
  vipr_req_t             req_q;

  logic [81:0]           wdata_all;
  logic [81:0]           cand_hi;
  logic [81:0]           cand_lo;
  logic [81:0]           cand;
  logic                  win_valid;
  logic                  win_high;
  logic [VIPR_VEC_W-1:0] win_vec;
  logic                  take;
  logic                  ret;
  logic                  gie_wr;
  logic [81:0]           flag_hit;

  assign wdata_all = spread(bus.wdata);
  assign flag_hit  = wr_hit(bus, VIPR_FLAG_BASE);
  assign gie_wr    = bus.wr && (bus.addr == VIPR_CTRL_ADR);
  // Only a request the core actually saw as valid is taken
  assign take      = core_ack && req_q.valid && !gie_wr;
  assign ret       = core_ret && (state_q != VIPR_ST_MAIN) && !gie_wr;

  // ----------------------------------------
  // Resolution
  // ----------------------------------------
  // Candidates split by selected level and masked by the level's global enable
  assign cand_hi = flag_q & en_q & lvl_q & VIPR_ASSIGNED & {82{gieh_q}};
  assign cand_lo = flag_q & en_q & ~lvl_q & VIPR_ASSIGNED & {82{giel_q}};

  // High level first, then fixed order within the level
  always_comb
  begin
    win_high  = (cand_hi != 82'h0);
    cand      = win_high ? cand_hi : cand_lo;
    win_vec   = lowest(cand);
    // Main takes either level, a low routine only high, a high routine none
    case (state_q)
      VIPR_ST_MAIN: win_valid = (cand != 82'h0);
      VIPR_ST_LOW:  win_valid = win_high;
      default:      win_valid = 1'b0;
    endcase
  end

  // Offer registered; dropped on the taking edge so a stale vector never repeats
  always_ff @(posedge clk)
  begin
    if (!nrst)
      req_q <= '0;
    else if (take || gie_wr)
      req_q <= '0;
    else
      req_q <= '{valid: win_valid, high: win_high, vec: win_vec};
  end

  assign core_req = req_q;

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  // Hardware set beats any clear in the same cycle; summary bits follow the source
  always_ff @(posedge clk)
  begin
    if (!nrst)
      flag_q <= '0;
    else
    begin
      for (int i = 0; i < VIPR_NUM_VEC; i++)
      begin
        if (SUMMARY_MASK[i])
          flag_q[i] <= src_summary[i];
        else if (src_set[i])
          flag_q[i] <= 1'b1;
        else if (flag_hit[i])
          flag_q[i] <= wdata_all[i];
        else if (AUTO_CLR_MASK[i] && take && (req_q.vec == VIPR_VEC_W'(i)))
          flag_q[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Enables and level selects
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      en_q  <= '0;
      lvl_q <= '0;
    end
    else
    begin
      en_q  <= (en_q & ~wr_hit(bus, VIPR_EN_BASE)) | (wdata_all & wr_hit(bus, VIPR_EN_BASE));
      lvl_q <= (lvl_q & ~wr_hit(bus, VIPR_LVL_BASE)) | (wdata_all & wr_hit(bus, VIPR_LVL_BASE));
    end
  end

  // Global enables change only by software, never by servicing
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      giel_q <= VIPR_CTRL_RST[VIPR_CTRL_GIEL];
      gieh_q <= VIPR_CTRL_RST[VIPR_CTRL_GIEH];
    end
    else if (gie_wr)
    begin
      giel_q <= bus.wdata[VIPR_CTRL_GIEL];
      gieh_q <= bus.wdata[VIPR_CTRL_GIEH];
    end
  end

  // ----------------------------------------
  // Execution state
  // ----------------------------------------
  // nested_q remembers a low routine under a high one
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q  <= VIPR_ST_MAIN;
      nested_q <= 1'b0;
    end
    else if (gie_wr)
    begin
      state_q  <= VIPR_ST_MAIN;
      nested_q <= 1'b0;
    end
    else if (take)
    begin
      state_q  <= req_q.high ? VIPR_ST_HIGH : VIPR_ST_LOW;
      nested_q <= (state_q == VIPR_ST_LOW);
    end
    else if (ret)
    begin
      state_q  <= nested_q ? VIPR_ST_LOW : VIPR_ST_MAIN;
      nested_q <= 1'b0;
    end
  end

  // Working register holds the vector of the latest taken request
  always_ff @(posedge clk)
  begin
    if (!nrst)
      core_working_register_q <= '0;
    else if (take)
      core_working_register_q <= req_q.vec;
  end

  // ----------------------------------------
  // Event status and interrupt
  // ----------------------------------------
  // Read of the status clears it, but a new event in that cycle stays
  always_ff @(posedge clk)
  begin
    if (!nrst)
      evt_q <= '0;
    else
    begin
      evt_q <= ((bus.rd && bus.addr == VIPR_EVT_ADR) ? 3'h0 : evt_q)
               | {gie_wr, ret, take};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      emsk_q <= VIPR_EMSK_RST;
    else if (bus.wr && bus.addr == VIPR_EMSK_ADR)
      emsk_q <= bus.wdata[2:0];
  end

  assign irq = |(evt_q & emsk_q);

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (!bus.rd)
      rdata <= 8'h00;
    else if (bus.addr >= VIPR_FLAG_BASE && bus.addr < VIPR_FLAG_BASE + 8'h0B)
      rdata <= lane(flag_q, int'(bus.addr - VIPR_FLAG_BASE));
    else if (bus.addr >= VIPR_EN_BASE && bus.addr < VIPR_EN_BASE + 8'h0B)
      rdata <= lane(en_q, int'(bus.addr - VIPR_EN_BASE));
    else if (bus.addr >= VIPR_LVL_BASE && bus.addr < VIPR_LVL_BASE + 8'h0B)
      rdata <= lane(lvl_q, int'(bus.addr - VIPR_LVL_BASE));
    else if (bus.addr == VIPR_CTRL_ADR)
      rdata <= {6'h00, gieh_q, giel_q};
    else if (bus.addr == VIPR_STATE_ADR)
      rdata <= {5'h00, nested_q, state_q};
    else if (bus.addr == VIPR_CORE_WORKING_REGISTER_ADR)
      rdata <= {1'b0, core_working_register_q};
    else if (bus.addr == VIPR_EVT_ADR)
      rdata <= {5'h00, evt_q};
    else if (bus.addr == VIPR_EMSK_ADR)
      rdata <= {5'h00, emsk_q};
    else
      rdata <= 8'h00;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_take_from_main;
    take && (state_q == VIPR_ST_MAIN);
  endsequence

  sequence s_high_in_low;
    take && (state_q == VIPR_ST_LOW) && req_q.high;
  endsequence

  AST_NO_UNASSIGNED: assert property (@(posedge clk) disable iff (!nrst)
    win_valid |-> VIPR_ASSIGNED[win_vec])
    else $error("unassigned vector won");

  AST_LEVEL_FIRST: assert property (@(posedge clk) disable iff (!nrst)
    (cand_hi != 82'h0) |-> win_high && cand_hi[win_vec])
    else $error("high level candidate lost to low");

  AST_LOWEST_WINS: assert property (@(posedge clk) disable iff (!nrst)
    win_valid |-> cand[win_vec] && ((cand & ((82'h1 << win_vec) - 82'h1)) == 82'h0))
    else $error("smaller vector not chosen");

  AST_LOW_TAKES_HIGH_ONLY: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == VIPR_ST_LOW) && win_valid |-> win_high)
    else $error("low request accepted during low routine");

  AST_HIGH_BLOCKS_ALL: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == VIPR_ST_HIGH) |-> !win_valid)
    else $error("request accepted during high routine");

  AST_PENDING_OFFERED: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == VIPR_ST_MAIN) && ((cand_hi | cand_lo) != 82'h0) && !take && !gie_wr
    |=> req_q.valid)
    else $error("eligible pending request not offered");

  AST_CORE_WORKING_REGISTER_LOADED: assert property (@(posedge clk) disable iff (!nrst)
    take |=> core_working_register_q == $past(req_q.vec) && !req_q.valid)
    else $error("working register not loaded with taken vector");

  AST_STATE_ENTER: assert property (@(posedge clk) disable iff (!nrst)
    s_take_from_main |=> state_q == ($past(req_q.high) ? VIPR_ST_HIGH : VIPR_ST_LOW))
    else $error("state did not follow taken level");

  AST_NEST_ENTER: assert property (@(posedge clk) disable iff (!nrst)
    s_high_in_low |=> state_q == VIPR_ST_HIGH && nested_q)
    else $error("nested high entry not remembered");

  AST_NEST_RETURN: assert property (@(posedge clk) disable iff (!nrst)
    ret && (state_q == VIPR_ST_HIGH) && nested_q |=> state_q == VIPR_ST_LOW)
    else $error("return from nested high did not resume low");

  AST_GIE_KEPT: assert property (@(posedge clk) disable iff (!nrst)
    take |=> $stable(giel_q) && $stable(gieh_q))
    else $error("servicing changed global enables");

  AST_GIE_ABORT: assert property (@(posedge clk) disable iff (!nrst)
    gie_wr |=> state_q == VIPR_ST_MAIN && !nested_q && !req_q.valid)
    else $error("global enable write did not return to main");

  AST_SET_WINS: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> ((($past(src_set) & ~SUMMARY_MASK) & ~flag_q) == 82'h0))
    else $error("hardware set lost against clear");

  AST_SUMMARY_FOLLOWS: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> (((flag_q ^ $past(src_summary)) & SUMMARY_MASK) == 82'h0))
    else $error("summary flag not following source");

endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the interrupt priority resolver.
// Assumes one 50 MHz clock; the core model answers the handshake.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import vipr_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [81:0] AUTO = 82'h20;
  localparam logic [81:0] SUMM = 82'h2_0000_0000_0000_0000_0000;
  localparam logic [7:0]  RST_ADR [7] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h00, 8'h40};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  vipr_bus_t   bus = '0;
  logic [7:0]  rdata;
  logic [81:0] src_set = '0;
  logic [81:0] src_summary = '0;
  vipr_req_t   core_req;
  logic        core_ack;
  logic        core_ret;
  logic        irq;
  logic        ack_en = 1'b0;
  logic        stall = 1'b0;
  logic        ret_go = 1'b0;
  int          err_total = 0;
  int          num_checks = 0;
  logic [7:0]  d;
  logic [7:0]  g;
  logic [7:0]  e;
  logic [1:0]  gie;
  logic [87:0] en;
  logic [87:0] lv;
  logic [87:0] fl;
  logic [81:0] src;
  logic [81:0] pend;

  always #10 clk = ~clk;

  vipr_resolver #(.AUTO_CLR_MASK(AUTO), .SUMMARY_MASK(SUMM)) DUT (
    .clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .src_set(src_set),
    .src_summary(src_summary), .core_req(core_req), .core_ack(core_ack),
    .core_ret(core_ret), .irq(irq));

  vipr_core_model core (
    .clk(clk), .nrst(nrst), .core_req(core_req), .core_ack(core_ack),
    .core_ret(core_ret), .ack_en(ack_en), .stall(stall), .ret_go(ret_go));

  // ----------------------------------------
  // Tasks and functions
  // ----------------------------------------
  // Winner as {high, vector}; FF when nothing may be offered
  function automatic logic [7:0] exp_win(input logic [81:0] p, input logic [81:0] l);
    for (int h = 1; h >= 0; h--)
      for (int v = 0; v < 82; v++)
        if (p[v] && l[v] == h[0])
          return {h[0], v[6:0]};
    return 8'hFF;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A gap cycle after each access keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask

  task automatic pulse(input logic [81:0] s);
    @(posedge clk);
    src_set <= s;
    @(posedge clk);
    src_set <= '0;
  endtask

  task automatic ret();
    @(posedge clk);
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
  endtask

  // Lets the core take one offer, with random stalls before the ack
  task automatic serve(output logic [7:0] got);
    got = 8'hFF;
    @(posedge clk);
    ack_en <= 1'b1;
    stall <= 1'($urandom_range(1, 0));
    for (int i = 0; i < 10 && got == 8'hFF; i++)
    begin
      @(posedge clk);
      #1 if (core_req.valid === 1'b1) got = {core_req.high, core_req.vec};
    end
    for (int i = 0; i < 20 && got != 8'hFF && core_ack !== 1'b1; i++)
    begin
      @(posedge clk);
      stall <= 1'($urandom_range(1, 0));
      #1;
    end
    @(posedge clk);
    ack_en <= 1'b0;
    stall <= 1'b0;
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    #(20 * 20000);
    err_total++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(78559));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, unmapped place reads zero
    foreach (RST_ADR[i])
    begin
      rd(RST_ADR[i], d);
      chk(d, 8'h00);
    end
    // Nesting: low routine, then a late high source pre-empts it
    wr(VIPR_EMSK_ADR, 8'h01);
    wr(VIPR_CTRL_ADR, 8'h03);
    for (int b = 0; b < 11; b++)
      wr(VIPR_EN_BASE + 8'(b), 8'hFF);
    wr(VIPR_LVL_BASE + 8'h06, 8'h04);
    rd(VIPR_EVT_ADR, d);
    chk({7'h00, irq}, 8'h00);
    pulse(82'h400);
    serve(g);
    chk(g, 8'h0A);
    chk({7'h00, irq}, 8'h01);
    pulse(82'h4_0000_0000_0000);
    serve(g);
    chk(g, 8'hB2);
    rd(VIPR_STATE_ADR, d);
    chk(d, 8'h06);
    ret();
    rd(VIPR_STATE_ADR, d);
    chk(d, 8'h01);
    rd(VIPR_CORE_WORKING_REGISTER_ADR, d);
    chk(d, 8'h32);
    rd(VIPR_EVT_ADR, d);
    chk(d, 8'h03);
    chk({7'h00, irq}, 8'h00);
    rd(VIPR_CTRL_ADR, d);
    chk(d, 8'h03);
    wr(VIPR_CTRL_ADR, 8'h03);
    rd(VIPR_STATE_ADR, d);
    chk(d, 8'h00);
    rd(VIPR_EVT_ADR, d);
    chk(d, 8'h04);
    // Summary flag ignores writes and mirrors its source
    wr(VIPR_FLAG_BASE + 8'h0A, 8'hFF);
    rd(VIPR_FLAG_BASE + 8'h0A, d);
    chk(d, 8'h01);
    @(posedge clk);
    src_summary[81] <= 1'b1;
    rd(VIPR_FLAG_BASE + 8'h0A, d);
    chk(d, 8'h03);
    @(posedge clk);
    src_summary[81] <= 1'b0;
    // Random levels, enables, global enables and request sets
    for (int it = 0; it < 40; it++)
    begin
      gie = 2'($urandom_range(3, 0));
      en = 88'({$urandom, $urandom, $urandom});
      lv = 88'({$urandom, $urandom, $urandom});
      src = '0;
      repeat (3) src[$urandom_range(81, 0)] = 1'b1;
      if (it == 0)
      begin
        gie = 2'h3;
        en[5] = 1'b1;
        src = 82'h20;
      end
      wr(VIPR_CTRL_ADR, {6'h00, gie});
      rd(VIPR_STATE_ADR, d);
      chk(d, 8'h00);
      for (int b = 0; b < 11; b++)
      begin
        wr(VIPR_FLAG_BASE + 8'(b), 8'h00);
        wr(VIPR_EN_BASE + 8'(b), en[8*b +: 8]);
        wr(VIPR_LVL_BASE + 8'(b), lv[8*b +: 8]);
      end
      pulse(src);
      fl = {6'h00, src & ~SUMM};
      pend = fl[81:0] & en[81:0] & VIPR_ASSIGNED
           & ((lv[81:0] & {82{gie[1]}}) | (~lv[81:0] & {82{gie[0]}}));
      e = exp_win(pend, lv[81:0]);
      serve(g);
      chk(g, e);
      if (e != 8'hFF)
      begin
        if (AUTO[e[6:0]])
          fl[e[6:0]] = 1'b0;
        rd(VIPR_FLAG_BASE + {4'h0, e[6:3]}, d);
        chk(d, fl[8*e[6:3] +: 8]);
        rd(VIPR_CORE_WORKING_REGISTER_ADR, d);
        chk(d, {1'b0, e[6:0]});
        rd(VIPR_STATE_ADR, d);
        chk(d, e[7] ? 8'h02 : 8'h01);
        rd(VIPR_CTRL_ADR, d);
        chk(d, {6'h00, gie});
      end
    end
    end_of_test();
  end
endmodule

`default_nettype wire

// ---- sim/vipr_core_model.sv ----
// Core model: takes the offered vector and returns from routines.
// Assumes the resolver's core handshake on the same clock.
`timescale 1ns/1ps
`default_nettype none

module vipr_core_model
  import vipr_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      nrst,
  // Resolver side
  input  wire vipr_req_t core_req,
  output logic           core_ack,
  output logic           core_ret,
  // Bench control
  input  wire logic      ack_en,
  input  wire logic      stall,
  input  wire logic      ret_go
);
  // ----------------------------------------
  // Take offers
  // ----------------------------------------
  // One ack per offer; stall delays it like a busy core would
  always_ff @(posedge clk)
  begin
    if (!nrst)
      core_ack <= 1'b0;
    else
      core_ack <= core_req.valid && ack_en && !stall && !core_ack;
  end

  // Return pulse one cycle after the bench asks for it
  always_ff @(posedge clk)
  begin
    if (!nrst)
      core_ret <= 1'b0;
    else
      core_ret <= ret_go;
  end
endmodule

`default_nettype wire
